/* temp_sensor_pkg.sv */
// Constants, register map and link states for the temperature sensor register core.
// Assumes a 125 MHz system clock and a free-running sensor clock of 64 ns.
// Functional notes
// - Sample data on clock rise; change driven data only after clock fall.
// - Reset release enters conversion mode; reset returns everything to reset state.
// - Start is data falling while clock high; commands without one are ignored.
// - Stop is data rising while clock high; it ends every command.
// - Slave address is preamble 0011, three strap pins, then direction bit.
// - Matching address is acknowledged by pulling data low in the ninth clock.
// - Every byte written by the master is acknowledged in the ninth clock.
// - Master acknowledges read bytes; no acknowledge plus stop ends transmission.
// - Written word is committed to its register only at the stop.
// - Read direction returns the register chosen by the current pointer.
// - Selective read is pointer write, repeated start, then read-direction address.
// - Pointer selects the capability register after reset.
// - Conversions start at most every 100 ms on the sensor clock.
// - Shutdown keeps the last reading; reads never disturb conversions.
// - Reading outside alarm window or above critical limit flags an event.
// - All writable registers reset to zero.
// - Event output is disabled, active low, after reset.
// - A limit write creating an event condition raises it at once.
// - Limits are two's complement with least used bit of 0.25 degrees.
// - Reading bits 15 to 13 show the relation to the three limits.
// - Reading bits 12 to 0 are two's complement, 0.0625 degree steps.
// - Clock low too long inside a command resets the link, releasing data.
// - Shutdown bit set freezes the reading; clear lets it update.
package temp_sensor_pkg;
	localparam int unsigned CLK_PERIOD_NS    = 8;
	localparam int unsigned SENSOR_PERIOD_NS = 64;
	localparam int unsigned CONV_INTERVAL_MS = 100;
	localparam int unsigned CONV_CYCLES      = (CONV_INTERVAL_MS * 1000000) / SENSOR_PERIOD_NS;
	localparam int unsigned TIMEOUT_MS       = 25;
	localparam int unsigned TIMEOUT_CYCLES   = (TIMEOUT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [3:0] ADDR_PREAMBLE = 4'h3;

	localparam logic [2:0] REG_CAP  = 3'h0;
	localparam logic [2:0] REG_CFG  = 3'h1;
	localparam logic [2:0] REG_HIGH = 3'h2;
	localparam logic [2:0] REG_LOW  = 3'h3;
	localparam logic [2:0] REG_CRIT = 3'h4;
	localparam logic [2:0] REG_TEMP = 3'h5;
	localparam logic [2:0] REG_MAKER = 3'h6;
	localparam logic [2:0] REG_PART  = 3'h7;

	localparam logic [15:0] CAP_RESET   = 16'h0077;
	localparam logic [15:0] CFG_RESET   = 16'h0000;
	localparam logic [15:0] LIMIT_RESET = 16'h0000;
	localparam logic [15:0] CFG_WR_MASK = 16'h07cf;
	localparam logic [15:0] LIMIT_MASK  = 16'h1ffc;

	localparam int unsigned CFG_MODE       = 0;
	localparam int unsigned CFG_POL        = 1;
	localparam int unsigned CFG_CRIT_ONLY  = 2;
	localparam int unsigned CFG_CTRL       = 3;
	localparam int unsigned CFG_STS        = 4;
	localparam int unsigned CFG_CLEAR      = 5;
	localparam int unsigned CFG_ALARM_LOCK = 6;
	localparam int unsigned CFG_CRIT_LOCK  = 7;
	localparam int unsigned CFG_SENSOR_SHUTDOWN       = 8;

	localparam int unsigned TEMP_ABOVE_CRIT = 15;
	localparam int unsigned TEMP_ABOVE_HIGH = 14;
	localparam int unsigned TEMP_BELOW_LOW  = 13;
	localparam int unsigned TEMP_WIDTH      = 13;

	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [2:0] WRITE_BYTES   = 3'h3;

	typedef enum logic [6:0] {
		ST_IDLE     = 7'h01,
		ST_ADDR     = 7'h02,
		ST_ADDR_ACK = 7'h04,
		ST_RX       = 7'h08,
		ST_RX_ACK   = 7'h10,
		ST_TX       = 7'h20,
		ST_TX_ACK   = 7'h40
	} link_state_t;
endpackage : temp_sensor_pkg

/* temp_sensor_regs.sv */
// Two-wire slave link, register file, limit comparators and conversion timer.
// Assumes open-drain pins resolved outside; sensor clock and its reset are free running.
`timescale 1ns/1ns
`default_nettype none

module sync3 #(
	parameter int unsigned W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         i_clock,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_level
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	// A bit moves only when stages two and three agree
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			s1_r    <= INIT;
			s2_r    <= INIT;
			s3_r    <= INIT;
			o_level <= INIT;
		end else begin
			s1_r    <= i_async;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			o_level <= (s3_r & ~(s2_r ^ s3_r)) | (o_level & (s2_r ^ s3_r));
		end
	end
endmodule : sync3

module temp_sensor_regs import temp_sensor_pkg::*; #(
	parameter int unsigned TIMEOUT_CYCLES_P = TIMEOUT_CYCLES,
	parameter int unsigned CONV_CYCLES_P    = CONV_CYCLES,
	parameter logic [15:0] MAKER_CODE       = 16'h5a5a, // Arbitrary value
	parameter logic [15:0] PART_REV_CODE    = 16'h0101  // Arbitrary value
) (
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	input  wire logic        i_addr_strap_bit0,
	input  wire logic        i_addr_strap_bit1,
	input  wire logic        i_addr_strap_bit2,
	input  wire logic        i_sensor_clock,
	input  wire logic        i_sensor_rst_n,
	input  wire logic [12:0] i_sensor_code,
	output logic             o_sda_out,
	output logic             o_sda_oe,
	output logic             o_event_out,
	output logic             o_event_oe
);
	localparam int unsigned TW = $clog2(TIMEOUT_CYCLES_P + 1);
	localparam int unsigned CW = $clog2(CONV_CYCLES_P + 1);

	link_state_t     state_r;
	logic [3:0]      bit_cnt_r;
	logic [7:0]      shift_r;
	logic [2:0]      byte_idx_r;
	logic [2:0]      ptr_r;
	logic [7:0]      wr_hi_r;
	logic [15:0]     wr_word_r;
	logic [15:0]     tx_r;
	logic            tx_lo_r;
	logic            commit_r;
	logic            busy_r;
	logic [TW-1:0]   tmo_cnt_r;
	logic            scl_q;
	logic            sda_q;
	logic [4:0]      pins_f;
	logic [15:0]     cfg_r;
	logic [15:0]     high_r;
	logic [15:0]     low_r;
	logic [15:0]     crit_r;
	logic [12:0]     temp_r;
	logic            cond_q;
	logic            sts_r;
	logic            ack_tgl_r;
	logic            req_f;
	logic [1:0]      sens_in_f;
	logic [CW-1:0]   sens_cnt_r;
	logic            sens_req_r;
	logic [12:0]     sens_data_r;
	logic [15:0]     rd_word;
	logic [15:0]     temp_word;

	// Straps pass the filter too, so a slow strap never matches half set
	sync3 #(.W(5), .INIT(5'h18)) u_pin_sync (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_async ({i_scl, i_sda, i_addr_strap_bit2, i_addr_strap_bit1, i_addr_strap_bit0}),
		.o_level (pins_f)
	);

	wire scl_f     = pins_f[4];
	wire sda_f     = pins_f[3];
	wire scl_rise  = scl_f & ~scl_q;
	wire scl_fall  = ~scl_f & scl_q;
	wire start_evt = scl_f & scl_q & sda_q & ~sda_f;
	wire stop_evt  = scl_f & scl_q & ~sda_q & sda_f;
	wire tmo_hit   = busy_r && (tmo_cnt_r == TW'(TIMEOUT_CYCLES_P - 1));
	wire byte_done = bit_cnt_r == BITS_PER_BYTE;
	wire addr_match = shift_r[7:1] == {ADDR_PREAMBLE, pins_f[2:0]};

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_f;
			sda_q <= sda_f;
		end
	end

	// Counts only while clock is low inside a command
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			busy_r    <= 1'b0;
			tmo_cnt_r <= '0;
		end else begin
			if (start_evt)
				busy_r <= 1'b1;
			else if (stop_evt || tmo_hit)
				busy_r <= 1'b0;
			if (!busy_r || scl_f || tmo_hit)
				tmo_cnt_r <= '0;
			else
				tmo_cnt_r <= tmo_cnt_r + 1'b1;
		end
	end

	always_comb begin
		case (ptr_r)
			REG_CAP:   rd_word = CAP_RESET;
			REG_CFG:   rd_word = {cfg_r[15:5], sts_r & cfg_r[CFG_CTRL], cfg_r[3:0]};
			REG_HIGH:  rd_word = high_r;
			REG_LOW:   rd_word = low_r;
			REG_CRIT:  rd_word = crit_r;
			REG_TEMP:  rd_word = temp_word;
			REG_MAKER: rd_word = MAKER_CODE;
			default:   rd_word = PART_REV_CODE;
		endcase
	end

	// Slave link; data out changes only on clock fall, or is released at a timeout
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			state_r    <= ST_IDLE;
			bit_cnt_r  <= 4'h0;
			shift_r    <= 8'h00;
			byte_idx_r <= 3'h0;
			ptr_r      <= REG_CAP;
			wr_hi_r    <= 8'h00;
			wr_word_r  <= 16'h0000;
			tx_r       <= 16'h0000;
			tx_lo_r    <= 1'b0;
			commit_r   <= 1'b0;
			o_sda_oe   <= 1'b0;
			o_sda_out  <= 1'b0;
		end else begin
			commit_r <= 1'b0;
			if (tmo_hit) begin
				state_r  <= ST_IDLE;
				o_sda_oe <= 1'b0;
			end else if (start_evt) begin
				state_r   <= ST_ADDR;
				bit_cnt_r <= 4'h0;
				o_sda_oe  <= 1'b0;
			end else if (stop_evt) begin
				// The clock rise just before a stop is counted as one bit
				if ((state_r == ST_RX) && (byte_idx_r == WRITE_BYTES) && (bit_cnt_r <= 4'h1))
					commit_r <= 1'b1;
				state_r  <= ST_IDLE;
				o_sda_oe <= 1'b0;
			end else begin
				if (scl_rise && (state_r == ST_ADDR || state_r == ST_RX)) begin
					shift_r   <= {shift_r[6:0], sda_f};
					bit_cnt_r <= bit_cnt_r + 1'b1;
				end
				case (state_r)
					ST_ADDR: begin
						if (scl_fall && byte_done) begin
							if (addr_match) begin
								state_r  <= ST_ADDR_ACK;
								o_sda_oe <= 1'b1;
								tx_lo_r  <= shift_r[0];
							end else begin
								state_r <= ST_IDLE;
							end
						end
					end
					ST_ADDR_ACK: begin
						if (scl_fall) begin
							bit_cnt_r  <= 4'h0;
							byte_idx_r <= 3'h0;
							if (tx_lo_r) begin
								state_r  <= ST_TX;
								tx_r     <= rd_word;
								tx_lo_r  <= 1'b0;
								o_sda_oe <= ~rd_word[15];
							end else begin
								state_r  <= ST_RX;
								o_sda_oe <= 1'b0;
							end
						end
					end
					ST_RX: begin
						if (scl_fall && byte_done) begin
							state_r  <= ST_RX_ACK;
							o_sda_oe <= 1'b1;
							if (byte_idx_r != 3'h4)
								byte_idx_r <= byte_idx_r + 1'b1;
							if (byte_idx_r == 3'h0)
								ptr_r <= shift_r[2:0];
							if (byte_idx_r == 3'h1)
								wr_hi_r <= shift_r;
							if (byte_idx_r == 3'h2)
								wr_word_r <= {wr_hi_r, shift_r};
						end
					end
					ST_RX_ACK: begin
						if (scl_fall) begin
							state_r   <= ST_RX;
							bit_cnt_r <= 4'h0;
							o_sda_oe  <= 1'b0;
						end
					end
					ST_TX: begin
						if (scl_rise)
							bit_cnt_r <= bit_cnt_r + 1'b1;
						if (scl_fall) begin
							tx_r <= {tx_r[14:0], 1'b0};
							if (byte_done) begin
								state_r  <= ST_TX_ACK;
								o_sda_oe <= 1'b0;
							end else begin
								o_sda_oe <= ~tx_r[14];
							end
						end
					end
					ST_TX_ACK: begin
						// No acknowledge: stay off the bus until the next start
						if (scl_rise && sda_f)
							state_r <= ST_IDLE;
						else if (scl_fall) begin
							state_r   <= ST_TX;
							bit_cnt_r <= 4'h0;
							tx_lo_r   <= ~tx_lo_r;
							if (tx_lo_r) begin
								tx_r     <= rd_word;
								o_sda_oe <= ~rd_word[15];
							end else begin
								o_sda_oe <= ~tx_r[15];
							end
						end
					end
					default: begin
						state_r <= ST_IDLE;
					end
				endcase
			end
		end
	end

	wire locked     = cfg_r[CFG_ALARM_LOCK] | cfg_r[CFG_CRIT_LOCK];
	wire clear_evt  = commit_r && (ptr_r == REG_CFG) && wr_word_r[CFG_CLEAR];
	wire [15:0] cfg_new = wr_word_r & CFG_WR_MASK;

	// Register file; locks clear only at reset
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			cfg_r  <= CFG_RESET;
			high_r <= LIMIT_RESET;
			low_r  <= LIMIT_RESET;
			crit_r <= LIMIT_RESET;
		end else if (commit_r) begin
			if (ptr_r == REG_CFG) begin
				cfg_r[15:8] <= cfg_new[15:8];
				cfg_r[7:6]  <= cfg_r[7:6] | cfg_new[7:6];
				if (!locked)
					cfg_r[3:0] <= cfg_new[3:0];
			end else if ((ptr_r == REG_HIGH) && !cfg_r[CFG_ALARM_LOCK]) begin
				high_r <= wr_word_r & LIMIT_MASK;
			end else if ((ptr_r == REG_LOW) && !cfg_r[CFG_ALARM_LOCK]) begin
				low_r <= wr_word_r & LIMIT_MASK;
			end else if ((ptr_r == REG_CRIT) && !cfg_r[CFG_CRIT_LOCK]) begin
				crit_r <= wr_word_r & LIMIT_MASK;
			end
		end
	end

	// Limits and reading share bit weights, so compare directly
	wire above_crit = $signed(temp_r) > $signed(crit_r[TEMP_WIDTH-1:0]);
	wire above_high = $signed(temp_r) > $signed(high_r[TEMP_WIDTH-1:0]);
	wire below_low  = $signed(temp_r) < $signed(low_r[TEMP_WIDTH-1:0]);
	wire event_cond = cfg_r[CFG_CRIT_ONLY] ? above_crit : (above_crit | above_high | below_low);
	assign temp_word = {above_crit, above_high, below_low, temp_r};
	wire asserted   = sts_r & cfg_r[CFG_CTRL];

	// Shutdown freezes the event state as well as the reading
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			cond_q      <= 1'b0;
			sts_r       <= 1'b0;
			o_event_oe  <= 1'b0;
			o_event_out <= 1'b0;
		end else begin
			cond_q <= event_cond;
			if (!cfg_r[CFG_SENSOR_SHUTDOWN]) begin
				if (!cfg_r[CFG_MODE])
					sts_r <= event_cond;
				else if (event_cond && !cond_q)
					sts_r <= 1'b1;
				else if (clear_evt)
					sts_r <= 1'b0;
			end
			o_event_oe <= cfg_r[CFG_POL] ? ~asserted : asserted;
		end
	end

	// Reading crosses by toggle handshake; data stays put until acknowledged
	sync3 #(.W(1), .INIT(1'b0)) u_req_sync (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_async (sens_req_r),
		.o_level (req_f)
	);

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			temp_r    <= 13'h0000;
			ack_tgl_r <= 1'b0;
		end else if (req_f != ack_tgl_r) begin
			temp_r    <= sens_data_r;
			ack_tgl_r <= req_f;
		end
	end

	sync3 #(.W(2), .INIT(2'h0)) u_sens_sync (
		.i_clock (i_sensor_clock),
		.i_rst_n (i_sensor_rst_n),
		.i_async ({cfg_r[CFG_SENSOR_SHUTDOWN], ack_tgl_r}),
		.o_level (sens_in_f)
	);

	wire sens_sensor_shutdown  = sens_in_f[1];
	wire sens_idle  = sens_req_r == sens_in_f[0];
	wire sens_wrap  = sens_cnt_r == CW'(CONV_CYCLES_P - 1);

	// Timer runs on regardless of link traffic
	always_ff @(posedge i_sensor_clock) begin
		if (!i_sensor_rst_n) begin
			sens_cnt_r  <= '0;
			sens_req_r  <= 1'b0;
			sens_data_r <= 13'h0000;
		end else begin
			sens_cnt_r <= sens_wrap ? '0 : sens_cnt_r + 1'b1;
			if (sens_wrap && !sens_sensor_shutdown && sens_idle) begin
				sens_data_r <= i_sensor_code;
				sens_req_r  <= ~sens_req_r;
			end
		end
	end

	sequence s_addr_end;
		state_r == ST_ADDR && scl_fall && byte_done && !tmo_hit && !stop_evt;
	endsequence

	sequence s_rx_end;
		state_r == ST_RX && scl_fall && byte_done && !tmo_hit && !stop_evt;
	endsequence

	a_addr_ack: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(s_addr_end ##0 addr_match) |=> o_sda_oe && state_r == ST_ADDR_ACK)
		else $error("address match not acknowledged");
	a_addr_reject: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(s_addr_end ##0 !addr_match) |=> !o_sda_oe [*2])
		else $error("foreign address drove data");
	a_rx_ack: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		s_rx_end |=> o_sda_oe && state_r == ST_RX_ACK)
		else $error("written byte not acknowledged");
	a_commit_stop: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		commit_r |-> $past(stop_evt) && state_r == ST_IDLE)
		else $error("commit without stop");
	a_ptr_reset: assert property (@(posedge i_clock)
		!i_rst_n |=> ptr_r == REG_CAP)
		else $error("pointer not at capability after reset");
	a_sda_edge: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		$changed(o_sda_oe) |-> $past(scl_fall || start_evt || stop_evt || tmo_hit))
		else $error("data changed away from clock fall");
	a_timeout_rel: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		tmo_hit |=> !o_sda_oe && state_r == ST_IDLE && !busy_r)
		else $error("timeout did not release link");
	a_event_now: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		($rose(event_cond) && !cfg_r[CFG_MODE] && !cfg_r[CFG_SENSOR_SHUTDOWN]) |=> sts_r)
		else $error("event not raised at once");
	a_sense_freeze: assert property (@(posedge i_sensor_clock) disable iff (!i_sensor_rst_n)
		sens_sensor_shutdown |=> $stable(sens_req_r) && $stable(sens_data_r))
		else $error("reading changed in shutdown");
	a_conv_bound: assert property (@(posedge i_sensor_clock) disable iff (!i_sensor_rst_n)
		sens_cnt_r < CW'(CONV_CYCLES_P))
		else $error("conversion interval overrun");
endmodule : temp_sensor_regs

`default_nettype wire

/* i2c_host_model.sv */
// Two-wire bus master model: drives the clock and pulls the data wire low.
// Assumes the bench resolves the open-drain data wire and feeds it back on i_sda.
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model #(
	parameter int Q = 13
) (
	input  wire logic i_clock,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_oe
);
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	// One third of a bit; moves land just after a system clock edge
	task automatic q();
		repeat (Q) @(posedge i_clock);
		#1;
	endtask : q
	// Start or repeated start: data falls while clock high
	task automatic start();
		o_sda_oe = 1'b0;
		q();
		o_scl = 1'b1;
		q();
		o_sda_oe = 1'b1;
		q();
		o_scl = 1'b0;
		q();
	endtask : start
	// Stop: data rises while clock high
	task automatic stop();
		o_sda_oe = 1'b1;
		q();
		o_scl = 1'b1;
		q();
		o_sda_oe = 1'b0;
		q();
	endtask : stop
	task automatic lo();
		o_scl = 1'b0;
		q();
	endtask : lo
	// Data only changes while clock is low, sampled late in the high phase
	task automatic bit_io(input logic b, output logic r);
		o_sda_oe = ~b;
		q();
		o_scl = 1'b1;
		q();
		r = i_sda;
		o_scl = 1'b0;
		q();
	endtask : bit_io
	// Msb first, then the ninth clock for the acknowledge
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, ack);
	endtask : wr_byte
	task automatic rd_byte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(nack, r);
	endtask : rd_byte
endmodule : i2c_host_model
`default_nettype wire

/* tb_i2c_temp_sensor_regs.sv */
// Self-checking bench for the sensor register core against a behavioural model.
// Assumes the two-wire master model and the design package are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_i2c_temp_sensor_regs import temp_sensor_pkg::*; ;
	localparam int          TO = 100;
	localparam int          CV = 64;
	localparam logic [15:0] MK = 16'h3c3c; // Arbitrary value
	localparam logic [15:0] PR = 16'h0202; // Arbitrary value
	logic        clk, rst_n, s_clk, s_rst_n, scl, m_oe, sda, sda_out, sda_oe, ev_out, ev_oe, a;
	logic [2:0]  strap, ptr;
	logic [12:0] code, tcode;
	logic [15:0] mreg [8];
	int          fail_count, n_checks;
	// Open-drain wire with pull-up
	assign sda = (sda_oe ? sda_out : 1'b1) & ~m_oe;
	i2c_host_model #(.Q(8)) m_i (.i_clock(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
	temp_sensor_regs #(.TIMEOUT_CYCLES_P(TO), .CONV_CYCLES_P(CV), .MAKER_CODE(MK), .PART_REV_CODE(PR))
	temp_sensor_regs_i (.i_clock(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
		.i_addr_strap_bit0(strap[0]), .i_addr_strap_bit1(strap[1]), .i_addr_strap_bit2(strap[2]),
		.i_sensor_clock(s_clk), .i_sensor_rst_n(s_rst_n), .i_sensor_code(code),
		.o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_event_out(ev_out), .o_event_oe(ev_oe));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		s_clk = 1'b0;
		#3;
		forever #32 s_clk = ~s_clk;
	end
	// {above crit, above high, below low}; limits are multiples of four, codes never are
	function automatic logic [2:0] rel();
		return {$signed(tcode) > $signed(mreg[4][12:0]), $signed(tcode) > $signed(mreg[2][12:0]),
			$signed(tcode) < $signed(mreg[3][12:0])};
	endfunction : rel
	function automatic logic asrt();
		return mreg[1][3] & (mreg[1][2] ? rel() == 3'b100 || rel() > 3'b100 : |rel());
	endfunction : asrt
	function automatic logic evx();
		return mreg[1][1] ? ~asrt() : asrt();
	endfunction : evx
	function automatic logic [15:0] exp_rd(input int r);
		if (r == 1) return mreg[1] | {11'h0, asrt(), 4'h0};
		if (r == 5) return {rel(), tcode};
		return mreg[r];
	endfunction : exp_rd
	task automatic chk16(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk16
	task automatic chk1(input logic g, input logic e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk1
	task automatic wr(input logic [2:0] r, input logic [15:0] d, input int n);
		m_i.start();
		m_i.wr_byte({ADDR_PREAMBLE, strap, 1'b0}, a);
		chk1(a, 1'b0);
		m_i.wr_byte({5'($urandom), r}, a);
		chk1(a, 1'b0);
		for (int i = 0; i < n; i++) begin
			m_i.wr_byte(i[0] ? d[7:0] : d[15:8], a);
			chk1(a, 1'b0);
		end
		m_i.stop();
		ptr = r;
		if (n == 2 && r == 1) mreg[1] = d & CFG_WR_MASK;
		if (n == 2 && r >= 2 && r <= 4) mreg[r] = d & LIMIT_MASK;
		repeat (8) @(posedge clk);
		#1;
		chk1(ev_oe, evx());
		chk1(ev_out, 1'b0);
	endtask : wr
	task automatic rd(input logic [2:0] r, input logic sel, input int nw);
		logic [15:0] w;
		if (sel) begin
			m_i.start();
			m_i.wr_byte({ADDR_PREAMBLE, strap, 1'b0}, a);
			m_i.wr_byte({5'($urandom), r}, a);
			ptr = r;
		end
		m_i.start();
		m_i.wr_byte({ADDR_PREAMBLE, strap, 1'b1}, a);
		chk1(a, 1'b0);
		for (int i = 0; i < nw; i++) begin
			m_i.rd_byte(1'b0, w[15:8]);
			m_i.rd_byte(i == nw - 1, w[7:0]);
			chk16(w, exp_rd(ptr));
		end
		m_i.stop();
	endtask : rd
	task automatic setc(input logic [12:0] v);
		@(posedge s_clk);
		#1;
		code = v;
		repeat (1200) @(posedge clk);
	endtask : setc
	task automatic close_out();
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out
	// About 60k cycles of traffic expected
	initial begin
		repeat (95000) @(posedge clk);
		fail_count++;
		$display("watchdog expired");
		close_out();
	end
	initial begin
		void'($urandom(79587));
		fail_count = 0;
		n_checks = 0;
		rst_n = 1'b0;
		s_rst_n = 1'b0;
		strap = 3'($urandom);
		code = 13'h1fff;
		tcode = code;
		ptr = REG_CAP;
		mreg = '{CAP_RESET, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, MK, PR};
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
		s_rst_n = 1'b1;
		repeat (5) @(posedge clk);
		chk1(ev_oe, 1'b0);
		chk1(sda_oe, 1'b0);
		rd(0, 1'b0, 1);
		$display("test reset done");
		for (int r = 0; r < 8; r++) begin
			rd(3'(r), 1'b1, 1);
			wr(3'(r), r == 1 ? 16'($urandom) & 16'h0602 : 16'($urandom), 2);
			rd(3'(r), 1'b1, 1);
		end
		$display("test register map done");
		wr(2, 16'($urandom), 1);
		rd(2, 1'b1, 1);
		wr(3, 16'($urandom), 3);
		rd(3, 1'b0, 2);
		$display("test byte count done");
		m_i.start();
		m_i.wr_byte({ADDR_PREAMBLE, ~strap, 1'b1}, a);
		chk1(a, 1'b1);
		m_i.stop();
		m_i.start();
		m_i.wr_byte({4'h2, strap, 1'b0}, a);
		chk1(a, 1'b1);
		m_i.stop();
		m_i.lo();
		m_i.wr_byte({ADDR_PREAMBLE, strap, 1'b1}, a);
		chk1(a, 1'b1);
		m_i.stop();
		$display("test address done");
		setc({11'($urandom), 2'b01});
		tcode = code;
		rd(5, 1'b1, 1);
		wr(1, 16'h0100, 2);
		// Let the shutdown bit cross into the sensor domain first
		repeat (64) @(posedge clk);
		setc({11'($urandom), 2'b01});
		rd(5, 1'b1, 1);
		wr(1, 16'h0000, 2);
		repeat (1200) @(posedge clk);
		tcode = code;
		rd(5, 1'b1, 1);
		$display("test conversion done");
		setc(13'h0191);
		tcode = code;
		wr(3, 16'h0000, 2);
		wr(2, 16'h0640, 2);
		wr(4, 16'h07f0, 2);
		wr(1, 16'h0008, 2);
		wr(2, 16'h0100, 2);
		for (int c = 0; c < 4; c++) begin
			wr(1, {12'h000, 1'b1, 2'(c), 1'b0}, 2);
			rd(1, 1'b1, 1);
		end
		wr(4, 16'h0100, 2);
		rd(5, 1'b1, 1);
		$display("test event done");
		rd(0, 1'b1, 1);
		m_i.start();
		m_i.wr_byte({ADDR_PREAMBLE, strap, 1'b1}, a);
		chk1(sda_oe, 1'b1);
		repeat (2 * TO) @(posedge clk);
		#1;
		chk1(sda_oe, 1'b0);
		m_i.stop();
		rd(0, 1'b1, 1);
		$display("test timeout done");
		close_out();
	end
endmodule : tb_i2c_temp_sensor_regs
`default_nettype wire
